// ===== supervisor_io_pkg.sv
// Purpose: Shared constants, register map and carrier types for the supervisor I/O conditioning block
// Assumes: 125 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   Every register word resets to zero; zero means weak pull-down on every output
package supervisor_io_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned FILT_MAX_US   = 100;
  localparam int unsigned FILT_MAX_CYC  = FILT_MAX_US * CYC_PER_US;
  localparam int unsigned TICK_HZ       = 100_000;
  localparam int unsigned TICK_HALF_CYC = CLK_HZ / (2 * TICK_HZ);
  localparam int unsigned TIME_W        = 14;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned N_DED  = 5;
  localparam int unsigned N_DUAL = 5;
  localparam int unsigned N_DET  = N_DED + N_DUAL;
  localparam int unsigned N_OUT  = 10;
  localparam int unsigned N_PUMP = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0]  DET_BASE    = 8'h00;
  localparam logic [7:0]  DIN_BASE    = 8'h40;
  localparam logic [7:0]  OUT_BASE    = 8'h60;
  localparam logic [7:0]  STATUS_ADDR = 8'h90;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] DET_MASK    = 32'h7f7f_ffff;
  localparam logic [31:0] DIN_MASK    = 32'h007f_7f07;
  localparam logic [31:0] OUT_MASK    = 32'h0000_0077;

  // Detector word fields
  localparam int unsigned DET_UV_LSB   = 0;
  localparam int unsigned DET_OV_LSB   = 8;
  localparam int unsigned DET_HYST_LSB = 16;
  localparam int unsigned DET_KIND_LSB = 21;
  localparam int unsigned DET_FILT_LSB = 24;
  // Digital input word fields
  localparam int unsigned DIN_DIG_BIT   = 0;
  localparam int unsigned DIN_EDGE_BIT  = 1;
  localparam int unsigned DIN_PD_BIT    = 2;
  localparam int unsigned DIN_FILT_LSB  = 8;
  localparam int unsigned DIN_PULSE_LSB = 16;
  // Output word fields
  localparam int unsigned OUT_SRC_LSB  = 0;
  localparam int unsigned OUT_BIT_BIT  = 2;
  localparam int unsigned OUT_MODE_LSB = 4;
  // Status word fields
  localparam int unsigned ST_FAULT_LSB = 0;
  localparam int unsigned ST_WARN_LSB  = 10;
  localparam int unsigned ST_DIN_LSB   = 15;
  localparam int unsigned ST_LIVE_BIT  = 20;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {KIND_UV, KIND_OV, KIND_WINDOW, KIND_OFF} fault_kind_e;
  typedef enum logic [1:0] {SRC_ENGINE, SRC_BUS, SRC_CLOCK, SRC_NONE} out_src_e;
  typedef enum logic [2:0] {
    MODE_WEAK_PD, MODE_OPEN_DRAIN, MODE_PU_WEAK_VDD, MODE_PU_STRONG_VDD,
    MODE_PU_WEAK_SUPPLY, MODE_PU_STRONG_SUPPLY, MODE_STRONG_PD, MODE_CHARGE_PUMP
  } drive_mode_e;

  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] hyst;
    logic [7:0] ov_code;
    logic [7:0] uv_code;
  } det_cfg_s;

  typedef struct packed {
    drive_mode_e mode;
    logic        data;
  } out_pin_s;

endpackage

// ===== glitch_filter.sv
// Purpose: Programmable time-domain glitch filter for one level
// Assumes: Input already synchronised to clk_sys_in
// Notes:   Zero timeout is a straight combinational pass
`timescale 1ns/1ps
`default_nettype none
module glitch_filter
  import supervisor_io_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              reset_n_in,
  input  wire logic              level_in,
  input  wire logic [TIME_W-1:0] timeout_in,
  output logic                   level_out
);

  logic [TIME_W-1:0] cnt_q;
  logic              held_q;
  logic [TIME_W:0]   next_cnt;

  assign next_cnt = {1'b0, cnt_q} + {{TIME_W{1'b0}}, 1'b1};

  // A differing level must persist a full timeout before it is taken
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q  <= '0;
      held_q <= 1'b0;
    end else if (level_in == held_q || timeout_in == '0) begin
      cnt_q  <= '0;
      held_q <= level_in;
    end else if (next_cnt >= {1'b0, timeout_in}) begin
      cnt_q  <= '0;
      held_q <= level_in; // RULE2
    end else begin
      cnt_q <= next_cnt[TIME_W-1:0]; // RULE1
    end
  end

  assign level_out = (timeout_in == '0) ? level_in : held_q; // RULE20

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  short_pulse_blocked_a: assert property ( // RULE1
    (timeout_in != '0 && $stable(timeout_in) && level_in != held_q && next_cnt < {1'b0, timeout_in})
      |=> held_q == $past(held_q))
    else $error("filter output moved before the timeout ran out");

  long_pulse_passes_a: assert property ( // RULE2
    (timeout_in != '0 && level_in != held_q && next_cnt >= {1'b0, timeout_in})
      |=> held_q == $past(level_in))
    else $error("filter output did not follow after the timeout");

  zero_timeout_pass_a: assert property ( // RULE20
    timeout_in == '0 |-> level_out == level_in)
    else $error("zero timeout did not pass the level straight through");

endmodule // glitch_filter
`default_nettype wire

// ===== tick_divider.sv
// Purpose: Free-running square wave derived from the system clock
// Assumes: HALF_CYC is the number of system cycles per half period
// Notes:   Output comes straight from a flip-flop, so it is glitch free
`timescale 1ns/1ps
`default_nettype none
module tick_divider
  import supervisor_io_pkg::*;
#(
  parameter int unsigned HALF_CYC = TICK_HALF_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  output logic      tick_out
);

  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q    <= '0;
      tick_out <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q    <= '0;
      tick_out <= ~tick_out; // RULE13
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  tick_half_period_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // RULE13
    $changed(tick_out) |-> $past(cnt_q) == LAST)
    else $error("clock output toggled off the half-period boundary");

endmodule // tick_divider
`default_nettype wire

// ===== supervisor_io.sv
// Purpose: Input conditioning and output data selection for the supervisor
// Assumes: Comparator and pin inputs are asynchronous; engine and loader are on clk_sys_in
// Notes:   Registers reached over AHB-Lite; the loader writes the same map at power-up
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Filter hides any pulse shorter than its programmed timeout.
// RULE2: Longer pulses pass, delayed by exactly the timeout.
// RULE3: Timeout programmable from zero to 100 us, after comparator hysteresis.
// RULE4: Each of five dual inputs is either a detector or a logic input.
// RULE5: Digital-mode pin frees its detector onto supply inputs one to four, or high input.
// RULE6: Secondary detector shares primary range and reports warnings, not faults.
// RULE7: Warnings readable in status and ORed into one engine warning.
// RULE8: Digital inputs choose level or edge; level mode is a buffered copy.
// RULE9: Edge mode emits one pulse per transition, width zero to 100 us.
// RULE10: Digital inputs have the same glitch filter as detectors.
// RULE11: Each digital pin has a selectable weak pull-down.
// RULE12: Each output picks engine, bus bit or internal clock as data.
// RULE13: Internal 100 kHz clock available to any output.
// RULE14: Drive modes selectable; charge pump only on the first six outputs.
// RULE15: Unprogrammed configuration is all zero; outputs weakly pulled low.
// RULE16: Outputs follow configuration only after supply good and load latched.
// RULE17: Software should give first supply input a nonzero filter when scanning.
// RULE18: Detectors flag under, over or out-of-window against 8-bit codes.
// RULE19: Hysteresis is a 5-bit code, maximum 31, applied once out of tolerance.
// RULE20: Zero timeout passes the level straight through.
module supervisor_io
  import supervisor_io_pkg::*;
#(
  parameter int unsigned CYC_PER_US_P   = CYC_PER_US,
  parameter int unsigned FILT_MAX_CYC_P = FILT_MAX_CYC,
  parameter int unsigned TICK_HALF_P    = TICK_HALF_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Configuration loader
  input  wire logic        load_wr_in,
  input  wire logic [7:0]  load_addr_in,
  input  wire logic [31:0] load_data_in,
  input  wire logic        load_done_in,
  input  wire logic        supply_good_in,
  // Analog front end
  input  wire logic [N_DET-1:0]  uv_cmp_in,
  input  wire logic [N_DET-1:0]  ov_cmp_in,
  input  wire logic [N_DUAL-1:0] dual_function_input_in,
  output det_cfg_s [N_DET-1:0]   det_cfg_out,
  output logic [N_DUAL-1:0]      dual_digital_out,
  output logic [N_DUAL-1:0]      pulldown_en_out,
  // Sequencing engine
  input  wire logic [N_OUT-1:0]  engine_data_in,
  output logic [N_DET-1:0]       engine_inputs_out,
  output logic                   warning_out,
  // Programmable outputs
  output out_pin_s [N_OUT-1:0]   programmable_output_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration storage
  logic [31:0] det_q [N_DET];
  logic [31:0] din_q [N_DUAL];
  logic [31:0] out_q [N_OUT];
  logic        live_q;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        ap_wr_q;
  logic [7:0]  ap_addr_q;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  function automatic logic [7:0] word_addr(input logic [7:0] base, input int unsigned idx);
    word_addr = base + 8'(idx * 4);
  endfunction

  // Microsecond code to cycles, clamped at the longest filter
  function automatic logic [TIME_W-1:0] us_to_cyc(input logic [6:0] code);
    logic [TIME_W+7:0] cyc;
    cyc = (TIME_W+8)'(code) * (TIME_W+8)'(CYC_PER_US_P);
    if (cyc > (TIME_W+8)'(FILT_MAX_CYC_P)) begin
      cyc = (TIME_W+8)'(FILT_MAX_CYC_P); // RULE3
    end
    us_to_cyc = cyc[TIME_W-1:0];
  endfunction

  // The loader wins a collision with the bus; bus writes during loading are not expected
  assign wr_en   = load_wr_in | ap_wr_q;
  assign wr_addr = load_wr_in ? load_addr_in : ap_addr_q;
  assign wr_data = load_wr_in ? load_data_in : hwdata_in;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < N_DET; i++) det_q[i] <= CFG_RESET; // RULE15
      for (int i = 0; i < N_DUAL; i++) din_q[i] <= CFG_RESET;
      for (int i = 0; i < N_OUT; i++) out_q[i] <= CFG_RESET;
    end else if (wr_en) begin
      for (int i = 0; i < N_DET; i++) begin
        if (wr_addr == word_addr(DET_BASE, i)) det_q[i] <= wr_data & DET_MASK;
      end
      for (int i = 0; i < N_DUAL; i++) begin
        if (wr_addr == word_addr(DIN_BASE, i)) din_q[i] <= wr_data & DIN_MASK;
      end
      for (int i = 0; i < N_OUT; i++) begin
        if (wr_addr == word_addr(OUT_BASE, i)) out_q[i] <= wr_data & OUT_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, read data registered in the address phase
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < N_DET; i++) begin
      if (haddr_in[7:0] == word_addr(DET_BASE, i)) rd_word = det_q[i];
    end
    for (int i = 0; i < N_DUAL; i++) begin
      if (haddr_in[7:0] == word_addr(DIN_BASE, i)) rd_word = din_q[i];
    end
    for (int i = 0; i < N_OUT; i++) begin
      if (haddr_in[7:0] == word_addr(OUT_BASE, i)) rd_word = out_q[i];
    end
    if (haddr_in[7:0] == STATUS_ADDR) rd_word = status_word;
    if (haddr_in[31:8] != 24'h00_0000) rd_word = 32'h0000_0000;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ap_wr_q    <= 1'b0;
      ap_addr_q  <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end else if (hready_in) begin
      ap_wr_q   <= hsel_in && htrans_in == HTRANS_NONSEQ && hwrite_in && haddr_in[31:8] == 24'h00_0000;
      ap_addr_q <= haddr_in[7:0];
      if (hsel_in && htrans_in == HTRANS_NONSEQ && !hwrite_in) begin
        hrdata_out <= rd_word;
      end
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers for comparator, pin and supply inputs
  localparam int unsigned SYNC_W = 2 * N_DET + N_DUAL + 1;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [N_DET-1:0]  uv_s;
  logic [N_DET-1:0]  ov_s;
  logic [N_DUAL-1:0] pin_s;
  logic              supply_s;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {supply_good_in, dual_function_input_in, ov_cmp_in, uv_cmp_in};
      sync2_q <= sync1_q;
    end
  end

  assign {supply_s, pin_s, ov_s, uv_s} = sync2_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Supply fault detectors
  logic [N_DET-1:0] raw_fault;
  logic [N_DET-1:0] filt_fault;
  logic [N_DUAL-1:0] dig_sel;

  for (genvar i = 0; i < N_DUAL; i++) begin : g_sel
    assign dig_sel[i] = din_q[i][DIN_DIG_BIT]; // RULE4
  end

  for (genvar i = 0; i < N_DET; i++) begin : g_det
    fault_kind_e kind;
    assign kind = fault_kind_e'(det_q[i][DET_KIND_LSB +: 2]);
    always_comb begin
      case (kind)
        KIND_UV:     raw_fault[i] = uv_s[i]; // RULE18
        KIND_OV:     raw_fault[i] = ov_s[i];
        KIND_WINDOW: raw_fault[i] = uv_s[i] | ov_s[i];
        default:     raw_fault[i] = 1'b0;
      endcase
    end
    // Threshold and hysteresis codes go to the comparators; hysteresis is applied there
    assign det_cfg_out[i] = {det_q[i][DET_KIND_LSB +: 2], det_q[i][DET_HYST_LSB +: 5],
                             det_q[i][DET_OV_LSB +: 8], det_q[i][DET_UV_LSB +: 8]}; // RULE19
    glitch_filter u_filt (
      .clk_sys_in (clk_sys_in),
      .reset_n_in (reset_n_in),
      .level_in   (raw_fault[i]),
      .timeout_in (us_to_cyc(det_q[i][DET_FILT_LSB +: 7])), // RULE3
      .level_out  (filt_fault[i])
    );
  end

  // The analog side reroutes a digital-mode pin's detector to its dedicated supply input
  assign dual_digital_out = dig_sel; // RULE5

  ////////////////////////////////////////////////////////////////////////////////
  // Digital input blocks
  logic [N_DUAL-1:0] din_filt;
  logic [N_DUAL-1:0] din_prev_q;
  logic [N_DUAL-1:0] din_val;
  logic [TIME_W-1:0] pulse_q [N_DUAL];

  for (genvar i = 0; i < N_DUAL; i++) begin : g_din
    logic [TIME_W-1:0] width;
    assign width = us_to_cyc(din_q[i][DIN_PULSE_LSB +: 7]);
    glitch_filter u_filt (
      .clk_sys_in (clk_sys_in),
      .reset_n_in (reset_n_in),
      .level_in   (pin_s[i]),
      .timeout_in (us_to_cyc(din_q[i][DIN_FILT_LSB +: 7])), // RULE10
      .level_out  (din_filt[i])
    );
    // A zero width still yields one clock of pulse so the edge is never lost
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        din_prev_q[i] <= 1'b0;
        pulse_q[i]    <= '0;
      end else begin
        din_prev_q[i] <= din_filt[i];
        if (din_filt[i] != din_prev_q[i]) begin
          pulse_q[i] <= (width == '0) ? TIME_W'(1) : width; // RULE9
        end else if (pulse_q[i] != '0) begin
          pulse_q[i] <= pulse_q[i] - TIME_W'(1);
        end
      end
    end
    assign din_val[i] = din_q[i][DIN_EDGE_BIT] ? (pulse_q[i] != '0) : din_filt[i]; // RULE8
    assign pulldown_en_out[i] = dig_sel[i] & din_q[i][DIN_PD_BIT]; // RULE11
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Engine inputs and warnings
  logic [N_DUAL-1:0] warn_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      engine_inputs_out <= '0;
      warn_q            <= '0;
      warning_out       <= 1'b0;
    end else begin
      engine_inputs_out[N_DED-1:0] <= filt_fault[N_DED-1:0];
      for (int i = 0; i < N_DUAL; i++) begin
        engine_inputs_out[N_DED+i] <= dig_sel[i] ? din_val[i] : filt_fault[N_DED+i]; // RULE4
        warn_q[i] <= dig_sel[i] & filt_fault[N_DED+i]; // RULE6
      end
      warning_out <= |(dig_sel & filt_fault[N_DET-1:N_DED]); // RULE7
    end
  end

  assign status_word = {11'h000, live_q, din_val, warn_q, filt_fault}; // RULE7

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic tick;

  tick_divider #(.HALF_CYC(TICK_HALF_P)) u_tick (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .tick_out   (tick)
  );

  // Drops back to weak pull-down whenever the supply falls below the good level
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      live_q <= 1'b0;
    end else if (!supply_s) begin
      live_q <= 1'b0;
    end else if (load_done_in) begin
      live_q <= 1'b1; // RULE16
    end
  end

  for (genvar i = 0; i < N_OUT; i++) begin : g_out
    out_src_e    src;
    drive_mode_e mode;
    logic        data;
    assign src  = out_src_e'(out_q[i][OUT_SRC_LSB +: 2]);
    assign mode = drive_mode_e'(out_q[i][OUT_MODE_LSB +: 3]);
    always_comb begin
      case (src)
        SRC_ENGINE: data = engine_data_in[i]; // RULE12
        SRC_BUS:    data = out_q[i][OUT_BIT_BIT];
        SRC_CLOCK:  data = tick; // RULE13
        default:    data = 1'b0;
      endcase
    end
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        programmable_output_out[i] <= '{mode: MODE_WEAK_PD, data: 1'b0}; // RULE15
      end else if (!live_q) begin
        programmable_output_out[i] <= '{mode: MODE_WEAK_PD, data: 1'b0}; // RULE16
      end else if (mode == MODE_CHARGE_PUMP && i >= N_PUMP) begin
        programmable_output_out[i] <= '{mode: MODE_WEAK_PD, data: data}; // RULE14
      end else begin
        programmable_output_out[i] <= '{mode: mode, data: data}; // RULE14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  warning_or_a: assert property ( // RULE7
    warning_out == |warn_q)
    else $error("warning output is not the OR of the warnings");

  level_copy_a: assert property ( // RULE8
    (dig_sel[0] && !din_q[0][DIN_EDGE_BIT] && $stable(dig_sel[0])) |=> engine_inputs_out[N_DED] == $past(din_filt[0]))
    else $error("level mode did not copy the filtered input");

  edge_pulse_a: assert property ( // RULE9
    (dig_sel[0] && din_q[0][DIN_EDGE_BIT] && din_filt[0] != din_prev_q[0]) |=> ##1 engine_inputs_out[N_DED])
    else $error("edge did not produce a pulse");

  pulldown_select_a: assert property ( // RULE11
    pulldown_en_out[1] |-> (din_q[1][DIN_DIG_BIT] && din_q[1][DIN_PD_BIT]))
    else $error("pull-down enabled without digital selection");

  not_live_weak_a: assert property ( // RULE16
    !live_q |=> programmable_output_out[0].mode == MODE_WEAK_PD && !programmable_output_out[0].data)
    else $error("output driven before configuration latched");

  pump_limited_a: assert property ( // RULE14
    programmable_output_out[N_PUMP+1].mode != MODE_CHARGE_PUMP)
    else $error("charge pump selected on an output that lacks it");

  bus_source_a: assert property ( // RULE12
    (live_q && out_q[0][OUT_SRC_LSB +: 2] == 2'(SRC_BUS)) |=> programmable_output_out[0].data == $past(out_q[0][OUT_BIT_BIT]))
    else $error("bus-sourced output did not follow its bit");

  digital_routing_a: assert property ( // RULE4
    (!dig_sel[3] && $stable(dig_sel[3])) |=> engine_inputs_out[N_DED+3] == $past(filt_fault[N_DED+3]))
    else $error("detector-mode pin not routed as a detector");

  warn_not_fault_a: assert property ( // RULE6
    !dig_sel[2] |=> !warn_q[2])
    else $error("warning raised by a pin in detector mode");

  live_c:      cover property (load_done_in && supply_s ##1 live_q);
  warning_c:   cover property (warning_out);
  edge_c:      cover property (dig_sel[0] && din_q[0][DIN_EDGE_BIT] && engine_inputs_out[N_DED]);
  clock_out_c: cover property (live_q && out_q[2][OUT_SRC_LSB +: 2] == 2'(SRC_CLOCK) && programmable_output_out[2].data);

endmodule // supervisor_io
`default_nettype wire

// ===== rails_model.sv
// Purpose: Board-side model of supply comparators and logic pins
// Assumes: Levels change just after a rising edge
// Notes:   Undriven pins show the inverse of the last level unless pulled down
`timescale 1ns/1ps
`default_nettype none
module rails_model
  import supervisor_io_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic [N_DET-1:0]  uv_set_in,
  input  wire logic [N_DUAL-1:0] pin_set_in,
  input  wire logic [N_DUAL-1:0] pin_drv_in,
  input  wire logic [N_DUAL-1:0] pulldown_en_in,
  output logic [N_DET-1:0]       uv_out,
  output logic [N_DUAL-1:0]      pin_out
);
  always_ff @(posedge clk_sys_in) begin
    uv_out  <= uv_set_in;
    // A floating pin is only defined when the weak pull-down is on
    pin_out <= (pin_drv_in & pin_set_in) | (~pin_drv_in & ~pulldown_en_in & ~pin_out);
  end
endmodule // rails_model
`default_nettype wire

// ===== supervisor_io_tb_top.sv
// Purpose: Self-checking bench for supervisor_io
// Assumes: Shortened timing, two cycles per microsecond
// Notes:   Random data from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module supervisor_io_tb_top;
  import supervisor_io_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, ld = 0, sg = 0, lw = 0, rdy, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'h5a8c, r, ldat = 0;
  logic [7:0]  la = 0;
  logic [1:0]  htrans = 0;
  logic [N_DET-1:0] uvs = 0, ovs = 0, uv, eng_in;
  // Pins start driven low so the floating model never starts from an unknown level
  logic [N_DUAL-1:0] ps = 0, pdrv = '1, pins, pden, dig;
  logic [N_OUT-1:0] eng = 0;
  logic warn;
  out_pin_s [N_OUT-1:0] po;
  det_cfg_s [N_DET-1:0] dcfg;
  int mismatches = 0, checks = 0, i;
  always #4 clk = ~clk;
  supervisor_io #(.CYC_PER_US_P(2), .FILT_MAX_CYC_P(200), .TICK_HALF_P(4)) dut_u (
    .clk_sys_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(rdy), .hwdata_in(hwdata), .hrdata_out(hrdata),
    .hreadyout_out(rdy), .hresp_out(hresp), .load_wr_in(lw), .load_addr_in(la),
    .load_data_in(ldat), .load_done_in(ld), .supply_good_in(sg), .uv_cmp_in(uv),
    .ov_cmp_in(ovs), .dual_function_input_in(pins), .det_cfg_out(dcfg), .dual_digital_out(dig),
    .pulldown_en_out(pden), .engine_data_in(eng), .engine_inputs_out(eng_in), .warning_out(warn),
    .programmable_output_out(po));
  rails_model rm_u (.clk_sys_in(clk), .uv_set_in(uvs), .pin_set_in(ps), .pin_drv_in(pdrv),
    .pulldown_en_in(pden), .uv_out(uv), .pin_out(pins));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13); s = s ^ (s >> 17); return s ^ (s << 5);
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin mismatches++; $display("ERROR %0t got %h exp %h", $time, got, exp); end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1; haddr <= {24'h0, a}; htrans <= HTRANS_NONSEQ; hwrite <= w;
    do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
    htrans <= 2'h0; hwdata <= d;
    do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50) begin mismatches++; results(); end
  endtask
  // Drive a fault pulse and report whether it reached the engine
  task automatic pulse(input int len, output logic seen);
    seen = 0;
    uvs[0] <= 1'b1;
    repeat (len) @(posedge clk);
    uvs[0] <= 1'b0;
    repeat (16) begin @(posedge clk); seen = seen | (eng_in[0] === 1'b1); end
  endtask
  logic s, c0;
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    bus(0, OUT_BASE, 0); chk(r, CFG_RESET);
    chk(po[0], {MODE_WEAK_PD, 1'b0});
    bus(0, 8'hfc, 0); chk(r, 0);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      bus(1, OUT_BASE + 8'h04, seed); bus(0, OUT_BASE + 8'h04, 0); chk(r, seed & OUT_MASK);
    end
    bus(1, DET_BASE, 32'h0200_0000);
    pulse(3, s); chk(s, 0);
    pulse(6, s); chk(s, 1);
    bus(1, DET_BASE, 32'h0); pulse(1, s); chk(s, 1);
    bus(1, OUT_BASE, 32'h15); bus(1, OUT_BASE + 8'h08, 32'h12); bus(1, OUT_BASE + 8'h0c, 32'h60);
    chk(po[0], {MODE_WEAK_PD, 1'b0});
    sg <= 1; repeat (4) @(posedge clk); ld <= 1; @(posedge clk); ld <= 0;
    seed = xs(seed); eng <= seed[9:0]; repeat (4) @(posedge clk);
    chk(po[0], {MODE_OPEN_DRAIN, 1'b1});
    chk(po[3], {MODE_STRONG_PD, seed[3]});
    c0 = po[2].data; repeat (4) @(posedge clk); chk(po[2].data, {31'h0, ~c0});
    bus(1, DIN_BASE, 32'h5); @(posedge clk); chk(dig[0], 1); chk(pden[0], 1);
    ps[0] <= 1; pdrv[0] <= 1; uvs[5] <= 1; repeat (8) @(posedge clk);
    chk(eng_in[5], 1); chk(warn, 1);
    bus(0, STATUS_ADDR, 0); chk(r[ST_WARN_LSB], 1);
    bus(1, DET_BASE + 8'h04, 32'h0040_0000); ovs[1] <= 1'b1; repeat (8) @(posedge clk);
    chk(eng_in[1], 1); chk(dcfg[1].kind, 2); chk(hresp, 0);
    // Two back-to-back loader words: pump on output 4 is kept, on output 7 it falls back
    la <= OUT_BASE + 8'h10; ldat <= 32'h75; lw <= 1'b1; @(posedge clk);
    la <= OUT_BASE + 8'h1c; @(posedge clk); lw <= 1'b0; repeat (3) @(posedge clk);
    chk(po[4], {MODE_CHARGE_PUMP, 1'b1}); chk(po[7], {MODE_WEAK_PD, 1'b1});
    // Released pin must be held low by the pull-down, giving exactly one edge pulse
    bus(1, DIN_BASE, 32'h0003_0007); repeat (8) @(posedge clk); pdrv[0] <= 1'b0; i = 0;
    repeat (20) begin @(posedge clk); if (eng_in[N_DED] === 1'b1) i++; end
    chk(i, 3 * 2);
    results();
  end
  initial begin repeat (20000) @(posedge clk); mismatches++; results(); end
endmodule // supervisor_io_tb_top
`default_nettype wire
